//--- design/gpio_pkg.sv
// Constants for the general-purpose port block: register map, widths, reset values.
// Assumes a 32-bit APB master with byte offsets that are multiples of four.
package gpio_pkg;
	localparam int BIDIR_PORTS = 8;
	localparam int PORT_W = 8;
	localparam int NARROW_PORT = 5;
	localparam int NARROW_W = 4;
	localparam int RTO_PORT = 6;
	localparam int ADDR_W = 12;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [7:0] ANALOG_READ = 8'hFF;
	localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
	// Register kinds sit in bits [8:6] groups; port index in bits [4:2]
	localparam logic [ADDR_W-1:0] OFS_INPUT0 = 12'h000;
	localparam logic [ADDR_W-1:0] OFS_FSEL0 = 12'h004;
	localparam logic [ADDR_W-1:0] BASE_DIR = 12'h040;
	localparam logic [ADDR_W-1:0] BASE_DATA = 12'h080;
	localparam logic [ADDR_W-1:0] BASE_FSEL = 12'h0C0;
	localparam logic [ADDR_W-1:0] BASE_PULL = 12'h100;
	localparam int PULL_FIRST = 1;
	localparam int PULL_LAST = 3;
	typedef enum logic [2:0]
	{
		APB_IDLE = 3'b001,
		APB_SETUP = 3'b010,
		APB_ACCESS = 3'b100
	} apb_state_type;
endpackage

//--- design/pin_sync.sv
// Two-stage synchroniser for a bus of pin levels.
// Assumes inputs are asynchronous to clk.
module pin_sync #(
	parameter int WIDTH = 8
) (
	input wire logic clk, // system clock
	input wire logic rst_n, // synchronous reset, active low
	input wire logic [WIDTH-1:0] pinIn, // raw pin levels
	output logic [WIDTH-1:0] pinSync // synchronised levels
);
	logic [WIDTH-1:0] meta_r;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			meta_r <= '0;
			pinSync <= '0;
		end
		else
		begin
			meta_r <= pinIn;
			pinSync <= meta_r;
		end
	end
endmodule

//--- design/port_bit_ctrl.sv
// Per-port pin control: output enable, output value and pull-up enable.
// Assumes altOut/altOe come from peripherals on the same clock.
module port_bit_ctrl #(
	parameter int WIDTH = 8,
	parameter bit HAS_PULL = 1'b0
) (
	input wire logic [WIDTH-1:0] dirBits, // 1 = output
	input wire logic [WIDTH-1:0] dataBits, // output data latch
	input wire logic [WIDTH-1:0] fselBits, // 1 = alternative function
	input wire logic [WIDTH-1:0] pullBits, // pull-up select
	input wire logic [WIDTH-1:0] altOut, // peripheral output value
	input wire logic [WIDTH-1:0] altOe, // peripheral drives the pin
	output logic [WIDTH-1:0] pinOut, // pin output value
	output logic [WIDTH-1:0] pinOe, // pin output enable
	output logic [WIDTH-1:0] pullEn // pull-up on
);
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++)
		begin : g_bit
			always_comb
			begin
				if (fselBits[i])
				begin
					pinOut[i] = altOut[i];
					pinOe[i] = altOe[i];
					// Alternative output kills pull-up; input follows select only
					pullEn[i] = HAS_PULL && !altOe[i] && pullBits[i];
				end
				else
				begin
					pinOut[i] = dataBits[i];
					pinOe[i] = dirBits[i];
					pullEn[i] = HAS_PULL && !dirBits[i] && pullBits[i];
				end
			end
		end
	endgenerate
endmodule

//--- design/gpio_port_block.sv
// General-purpose port block: eight bidirectional ports, one input/analog port, APB slave.
// Assumes a synchronous APB master on clk and asynchronous pins.
// Behaviour
// - Seven 8-bit and one 4-bit bidirectional port plus one 8-bit input port.
// - Each bidirectional port has per-bit direction and output data registers.
// - Function select register picks general or peripheral function per bit.
// - Reading an input-direction bit returns the pin level.
// - Reading an output-direction bit returns the output data register bit.
// - Pin levels reach the read path only during a read strobe.
// - Input-only port bits choose digital input or analog channel.
// - Ports 1 to 3 have per-bit pull-up select registers.
// - Pull-up select counts only while the general pin is an input.
// - Pull-up forced off for general pins set as outputs.
// - Pull-up off for pins on a peripheral output function.
// - Peripheral input pins follow pull-up select, ignoring direction.
// - Function select registers keep contents across low-power mode.
// - 4-bit port offers trigger, timer event, plain pin, converter trigger.
// - All port 6 pins selectable as realtime output pins.
// - Analog-selected input-only bits read as 1.
// - Reset clears function select, direction, data and pull-up registers.
module gpio_port_block
	import gpio_pkg::*;
#(
	parameter int PORTS = gpio_pkg::BIDIR_PORTS
) (
	input wire logic clk, // system clock
	input wire logic rst_n, // synchronous reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [gpio_pkg::ADDR_W-1:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	input wire logic [3:0] pstrb, // APB byte strobes
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error on unmapped address
	input wire logic lowPower, // low-power mode entered
	input wire logic [7:0] inputPins, // input-only port pins
	output logic [7:0] analogSel, // per-bit analog channel enable
	input wire logic [PORTS*8-1:0] pinIn, // bidirectional pin levels, port n at [8n+7:8n]
	output logic [PORTS*8-1:0] pinOut, // pin drive values
	output logic [PORTS*8-1:0] pinOe, // pin output enables
	output logic [PORTS*8-1:0] pullEn, // pull-up enables
	input wire logic [PORTS*8-1:0] altOut, // peripheral output values
	input wire logic [PORTS*8-1:0] altOe, // peripheral output enables
	output logic [PORTS*8-1:0] altIn, // pin levels handed to peripherals
	output logic realtimeTriggerIn, // realtime output trigger from 4-bit port
	output logic timerEventIn, // timer event from 4-bit port
	output logic converterStartTriggerIn, // converter trigger from 4-bit port
	output logic [7:0] realtimeOutSel // port 6 bits on realtime output
);
	import gpio_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Register storage
	logic [7:0] direction_r [PORTS];
	logic [7:0] outData_r [PORTS];
	logic [7:0] funcSel_r [PORTS];
	logic [7:0] pullSel_r [PORTS];
	logic [7:0] funcSel0_r;
	logic [PORTS*8-1:0] pinSync;
	logic [7:0] inputSync;
	logic [PORTS*8-1:0] pinGated;
	logic [7:0] inputGated;
	logic [PORTS*8-1:0] dirFlat;
	logic [PORTS*8-1:0] dataFlat;
	logic [PORTS*8-1:0] fselFlat;
	logic [PORTS*8-1:0] pullFlat;
	logic [PORTS*8-1:0] pullRaw;
	logic [7:0] portMask [PORTS];
	logic wrStrobe;
	logic rdStrobe;
	logic [31:0] readWord;
	logic mapped;
	apb_state_type state_r;
	apb_state_type state_nxt;

	// Register index decode shared by write and read paths
	function automatic logic hitGroup(input logic [ADDR_W-1:0] addr,
		input logic [ADDR_W-1:0] base, input int port);
		hitGroup = (addr == base + ADDR_W'(port * 4));
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// APB slave sequencing; zero wait states
	always_comb
	begin
		case (state_r)
			APB_IDLE: state_nxt = psel ? APB_SETUP : APB_IDLE;
			APB_SETUP: state_nxt = APB_ACCESS;
			APB_ACCESS: state_nxt = (psel && !penable) ? APB_SETUP : APB_IDLE;
			default: state_nxt = APB_IDLE;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			state_r <= APB_IDLE;
		else
			state_r <= state_nxt;
	end

	assign pready = 1'b1;
	assign wrStrobe = psel && penable && pwrite && pstrb[0];
	assign rdStrobe = psel && !penable && !pwrite;

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers; sampled value gated into the read path, fed to peripherals continuously
	pin_sync #(.WIDTH(PORTS*8)) u_sync_bidir
	(
		.clk(clk),
		.rst_n(rst_n),
		.pinIn(pinIn),
		.pinSync(pinSync)
	);

	pin_sync #(.WIDTH(8)) u_sync_input
	(
		.clk(clk),
		.rst_n(rst_n),
		.pinIn(inputPins),
		.pinSync(inputSync)
	);

	// Input path opens only during the setup cycle of a read
	assign pinGated = rdStrobe ? pinSync : '0;
	assign inputGated = rdStrobe ? inputSync : '0;

	////////////////////////////////////////////////////////////////////////////////
	// Register writes
	genvar p;
	generate
		for (p = 0; p < PORTS; p++)
		begin : g_port
			// 4-bit port keeps only the low nibble
			assign portMask[p] = (p == NARROW_PORT) ? 8'h0F : 8'hFF;

			always_ff @(posedge clk)
			begin
				if (!rst_n)
				begin
					direction_r[p] <= REG_RESET;
					outData_r[p] <= REG_RESET;
					pullSel_r[p] <= REG_RESET;
				end
				else if (wrStrobe)
				begin
					if (hitGroup(paddr, BASE_DIR, p))
						direction_r[p] <= pwdata[7:0] & portMask[p];
					if (hitGroup(paddr, BASE_DATA, p))
						outData_r[p] <= pwdata[7:0] & portMask[p];
					if (hitGroup(paddr, BASE_PULL, p) && p >= PULL_FIRST && p <= PULL_LAST)
						pullSel_r[p] <= pwdata[7:0];
				end
			end

			// Only reset reinitialises; low-power entry leaves the selection alone
			always_ff @(posedge clk)
			begin
				if (!rst_n)
					funcSel_r[p] <= REG_RESET;
				else if (wrStrobe && hitGroup(paddr, BASE_FSEL, p))
					funcSel_r[p] <= pwdata[7:0] & portMask[p];
			end

			assign dirFlat[p*8 +: 8] = direction_r[p];
			assign dataFlat[p*8 +: 8] = outData_r[p];
			assign fselFlat[p*8 +: 8] = funcSel_r[p];
			assign pullFlat[p*8 +: 8] = pullSel_r[p];
		end
	endgenerate

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			funcSel0_r <= REG_RESET;
		else if (wrStrobe && paddr == OFS_FSEL0)
			funcSel0_r <= pwdata[7:0];
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pin control
	port_bit_ctrl #(.WIDTH(PORTS*8), .HAS_PULL(1'b1)) u_ctrl
	(
		.dirBits(dirFlat),
		.dataBits(dataFlat),
		.fselBits(fselFlat),
		.pullBits(pullFlat),
		.altOut(altOut),
		.altOe(altOe),
		.pinOut(pinOut),
		.pinOe(pinOe),
		.pullEn(pullRaw)
	);

	// Pull-ups exist only on ports 1 to 3
	generate
		for (p = 0; p < PORTS; p++)
		begin : g_pull
			assign pullEn[p*8 +: 8] = (p >= PULL_FIRST && p <= PULL_LAST) ?
				pullRaw[p*8 +: 8] : 8'h00;
		end
	endgenerate

	// Peripherals see synchronised pin levels continuously
	assign altIn = pinSync;
	assign analogSel = funcSel0_r;
	assign realtimeTriggerIn = pinSync[NARROW_PORT*8 + 3] & funcSel_r[NARROW_PORT][3];
	assign timerEventIn = pinSync[NARROW_PORT*8 + 2] & funcSel_r[NARROW_PORT][2];
	assign converterStartTriggerIn = pinSync[NARROW_PORT*8] & funcSel_r[NARROW_PORT][0];
	assign realtimeOutSel = funcSel_r[RTO_PORT];

	////////////////////////////////////////////////////////////////////////////////
	// Read mux, registered at the setup cycle so data is stable in the access phase
	always_comb
	begin
		readWord = ZERO_WORD;
		mapped = 1'b0;
		if (paddr == OFS_INPUT0)
		begin
			mapped = 1'b1;
			readWord[7:0] = (inputGated & ~funcSel0_r) | (ANALOG_READ & funcSel0_r);
		end
		if (paddr == OFS_FSEL0)
		begin
			mapped = 1'b1;
			readWord[7:0] = funcSel0_r;
		end
		for (int i = 0; i < PORTS; i++)
		begin
			if (hitGroup(paddr, BASE_DIR, i))
			begin
				mapped = 1'b1;
				readWord[7:0] = direction_r[i];
			end
			if (hitGroup(paddr, BASE_DATA, i))
			begin
				mapped = 1'b1;
				// Output bits read the latch, input bits the pin
				readWord[7:0] = ((outData_r[i] & direction_r[i]) |
					(pinGated[i*8 +: 8] & ~direction_r[i])) & portMask[i];
			end
			if (hitGroup(paddr, BASE_FSEL, i))
			begin
				mapped = 1'b1;
				readWord[7:0] = funcSel_r[i];
			end
			if (hitGroup(paddr, BASE_PULL, i) && i >= PULL_FIRST && i <= PULL_LAST)
			begin
				mapped = 1'b1;
				readWord[7:0] = pullSel_r[i];
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			prdata <= ZERO_WORD;
		else if (psel && !penable)
			prdata <= pwrite ? ZERO_WORD : readWord;
	end

	always_comb
	begin
		pslverr = psel && penable && !mapped;
	end
endmodule

//--- verification/gpio_port_sva.sv
// Checker for the port block: bus answer timing, read data, pull-up relations.
// Sees only the top module's ports; bound from tb_top.
module gpio_port_sva
	import gpio_pkg::*;
#(
	parameter int PORTS = 8
) (
	input wire logic clk, // clock
	input wire logic rst_n, // reset
	input wire logic psel, // select
	input wire logic penable, // enable
	input wire logic pwrite, // direction
	input wire logic [gpio_pkg::ADDR_W-1:0] paddr, // address
	input wire logic [31:0] prdata, // read data
	input wire logic pready, // ready
	input wire logic pslverr, // error
	input wire logic [7:0] analogSel, // analog bits
	input wire logic [PORTS*8-1:0] pinOe, // drive enables
	input wire logic [PORTS*8-1:0] pullEn // pull-ups
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////////////////////////////
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_read;
		psel && penable && !pwrite;
	endsequence
	property p_ready;
		psel && penable |-> pready;
	endproperty
	property p_errPhase;
		pslverr |-> psel && penable;
	endproperty
	// Read data only moves at a setup edge
	property p_hold;
		!(psel && !penable) |=> $stable(prdata);
	endproperty
	property p_upper;
		s_setup ##1 s_read |-> prdata[31:8] == 24'h0;
	endproperty
	property p_errZero;
		s_read |-> !pslverr || prdata == ZERO_WORD;
	endproperty
	property p_analog;
		s_read |-> paddr != OFS_INPUT0 || (prdata[7:0] & analogSel) == analogSel;
	endproperty
	property p_pullOff;
		(pinOe & pullEn) == '0;
	endproperty
	property p_pullPorts;
		pullEn[7:0] == 8'h00 && pullEn[PORTS*8-1:32] == '0;
	endproperty
	property p_reset;
		$rose(rst_n) |-> pinOe == '0 && pullEn == '0;
	endproperty
	a_ready: assert property (p_ready) else $error("access not answered");
	a_errPhase: assert property (p_errPhase) else $error("error outside access");
	a_hold: assert property (p_hold) else $error("read data moved");
	a_upper: assert property (p_upper) else $error("upper read bits set");
	a_errZero: assert property (p_errZero) else $error("refused read not zero");
	a_analog: assert property (p_analog) else $error("analog bit not one");
	a_pullOff: assert property (p_pullOff) else $error("pull-up on driven pin");
	a_pullPorts: assert property (p_pullPorts) else $error("pull-up on wrong port");
	a_reset: assert property (p_reset) else $error("pins not idle after reset");
endmodule

//--- verification/pin_model.sv
// Board model: what the outside circuit puts on each bidirectional pin.
// Assumes the board always drives a firm level where the block does not.
module pin_model #(
	parameter int W = 64
) (
	input wire logic [W-1:0] pinOut, // block drive value
	input wire logic [W-1:0] pinOe, // block drives pin
	input wire logic [W-1:0] boardLevel, // board level
	output logic [W-1:0] pinIn // resulting level
);
	// Never floating, so pull-ups never decide a level here
	assign pinIn = (pinOe & pinOut) | (~pinOe & boardLevel);
endmodule

//--- verification/tb_top.sv
// Bench for the port block: APB traffic, pin levels, peripheral hand-over.
// Assumes the gpio_pkg map and a board model on every bidirectional pin.
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import gpio_pkg::*;
	logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic lowPower = 1'b0, pready, pslverr, realtimeTriggerIn, timerEventIn;
	logic converterStartTriggerIn, err;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [3:0] pstrb = 4'hF;
	logic [7:0] inputPins = 8'h0, analogSel, realtimeOutSel, an, m, e;
	logic [63:0] pinIn, pinOut, pinOe, pullEn, altIn, altOut = '0, altOe = '0, board = '0;
	logic [7:0] dir [8], dat [8], fs [8], pu [8];
	int err_count = 0, checks = 0;
	always #5 clk = ~clk;
	gpio_port_block dut (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
		.prdata, .pready, .pslverr, .lowPower, .inputPins, .analogSel, .pinIn, .pinOut,
		.pinOe, .pullEn, .altOut, .altOe, .altIn, .realtimeTriggerIn, .timerEventIn,
		.converterStartTriggerIn, .realtimeOutSel);
	pin_model #(.W(64)) board_i (.pinOut, .pinOe, .boardLevel(board), .pinIn);
	////////////////////////////////////////////////////////////////
	function automatic logic [11:0] ad(logic [11:0] b, int n);
		return b + 12'(4 * n);
	endfunction
	function automatic logic [7:0] oeX(int n);
		return (fs[n] & altOe[8*n+:8]) | (~fs[n] & dir[n]);
	endfunction
	function automatic logic [7:0] outX(int n);
		return (fs[n] & altOut[8*n+:8]) | (~fs[n] & dat[n]);
	endfunction
	function automatic logic [7:0] pinX(int n);
		return (oeX(n) & outX(n)) | (~oeX(n) & board[8*n+:8]);
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdc(input logic [11:0] a, input logic [7:0] x);
		apb(1'b0, a, 32'h0);
		chk(rd, {24'h0, x});
	endtask
	task automatic test_done;
		$display("checks %0d err_count %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial
	begin
		repeat (30000) @(posedge clk);
		err_count++;
		test_done();
	end
	initial
	begin
		void'($urandom(43));
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		rdc(OFS_FSEL0, 8'h00);
		for (int n = 0; n < 8; n++)
		begin
			rdc(ad(BASE_DIR, n), 8'h00);
			rdc(ad(BASE_DATA, n), 8'h00);
			rdc(ad(BASE_FSEL, n), 8'h00);
			rdc(ad(BASE_PULL, n), 8'h00);
		end
		for (int r = 0; r < 12; r++)
		begin
			an = 8'($urandom);
			inputPins <= 8'($urandom);
			board <= {$urandom, $urandom};
			altOut <= {$urandom, $urandom};
			altOe <= {$urandom, $urandom};
			apb(1'b1, OFS_FSEL0, {24'h0, an});
			for (int n = 0; n < 8; n++)
			begin
				m = n == NARROW_PORT ? 8'h0F : 8'hFF;
				dir[n] = 8'($urandom) & m;
				dat[n] = 8'($urandom) & m;
				fs[n] = r < 6 ? 8'h00 : 8'($urandom) & m;
				pu[n] = 8'($urandom);
				apb(1'b1, ad(BASE_DIR, n), {24'h0, dir[n] | ~m});
				apb(1'b1, ad(BASE_DATA, n), {24'h0, dat[n]});
				apb(1'b1, ad(BASE_FSEL, n), {24'h0, fs[n]});
				apb(1'b1, ad(BASE_PULL, n), {24'h0, pu[n]});
				// Unmapped pull registers must have dropped the write
				if (n < PULL_FIRST || n > PULL_LAST)
					pu[n] = 8'h00;
			end
			repeat (4) @(posedge clk);
			for (int n = 0; n < 8; n++)
			begin
				m = n == NARROW_PORT ? 8'h0F : 8'hFF;
				chk(pinOe[8*n+:8] & m, oeX(n));
				chk(pinOut[8*n+:8] & oeX(n), outX(n) & oeX(n));
				chk(altIn[8*n+:8], pinX(n));
				chk(pullEn[8*n+:8], pu[n] & ~oeX(n));
				rdc(ad(BASE_DIR, n), dir[n]);
				rdc(ad(BASE_PULL, n), pu[n]);
				apb(1'b0, ad(BASE_DATA, n), 32'h0);
				chk(rd & {24'h0, ~fs[n]}, {24'h0, pinX(n) & ~fs[n] & m});
			end
			chk(analogSel, an);
			rdc(OFS_INPUT0, inputPins | an);
			chk(realtimeOutSel, fs[RTO_PORT]);
			e = pinX(NARROW_PORT) & fs[NARROW_PORT];
			chk({realtimeTriggerIn, timerEventIn, converterStartTriggerIn}, {e[3], e[2], e[0]});
		end
		lowPower <= 1'b1;
		repeat (3) @(posedge clk);
		rdc(OFS_FSEL0, an);
		for (int n = 0; n < 8; n++)
			rdc(ad(BASE_FSEL, n), fs[n]);
		lowPower <= 1'b0;
		apb(1'b1, 12'h200, 32'hFFFF_FFFF);
		chk({31'h0, err}, 32'h0000_0001);
		rdc(12'h200, 8'h00);
		chk({31'h0, err}, 32'h0000_0001);
		rdc(OFS_FSEL0, an);
		chk({31'h0, err}, 32'h0000_0000);
		test_done();
	end
endmodule
bind gpio_port_block gpio_port_sva #(.PORTS(PORTS)) chk_i (.clk, .rst_n, .psel, .penable,
	.pwrite, .paddr, .prdata, .pready, .pslverr, .analogSel, .pinOe, .pullEn);
